// file: hdl/uart_packetizer.sv
`timescale 1ns/1ps
module uart_packetizer
  import uart_pkt_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Serial line
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic cts_n_i,
  output logic rts_n_o,
  // Events
  output logic irq_o,
  output logic blk_rel_o
);

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
  } rx_st_e;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
  } tx_st_e;

  cfg_s cfg_r;
  logic [15:0] div_r, idle_set_r, win_set_r, os_cnt_r, idle_ms_r, win_ms_r;
  logic [10:0] thr_r, blk_cnt_r;
  logic [31:0] prdata_r, rdata;
  logic [3:0] sts_r, mask_r, ev;
  logic hit, apb_wr, apb_rd, os_tick, ms_tick, fire;
  logic [31:0] ms_pre_r;
  rx_st_e rx_st_r;
  tx_st_e tx_st_r;
  logic rx_s0_r, rx_s1_r, cts_s0_r, cts_s1_r;
  logic [3:0] rx_tk_r, tx_tk_r;
  logic [2:0] rx_bit_r, tx_bit_r, last_bit;
  logic [7:0] rx_sh_r, rx_byte, rx_data_r, tx_hold_r, tx_sh_r;
  logic rx_par_r, perr_r, rx_full_r, rx_done, store, ctl_rx;
  logic tx_full_r, tx_par_r, txd_r, rts_n_r, blk_rel_r;
  logic hw_fc, sw_fc, xoff_sent_r, xoff_rcv_r, pend_x, tx_go, tx_ld, clr_rx, clr_tx;

  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign apb_rd = psel_i && penable_i && !pwrite_i;
  assign clr_rx = apb_wr && paddr_i == A_CMD && pwdata_i[CMD_CLR_RX];
  assign clr_tx = apb_wr && paddr_i == A_CMD && pwdata_i[CMD_CLR_TX];
  assign last_bit = cfg_r.data7 ? 3'h6 : 3'h7;
  assign hw_fc = cfg_r.bridge && cfg_r.flow == FLOW_HW;
  assign sw_fc = cfg_r.bridge && cfg_r.flow == FLOW_SW;

  always_comb begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr_i)
      A_CTRL: rdata = {22'h0, cfg_r};
      A_BAUD: rdata = {16'h0000, div_r};
      A_THR: rdata = {21'h0, thr_r};
      A_IDLE: rdata = {16'h0000, idle_set_r};
      A_WIN: rdata = {16'h0000, win_set_r};
      A_CMD, A_TXD: rdata = 32'h0000_0000;
      A_RXD: rdata = {24'h00_0000, rx_data_r};
      A_STAT: rdata = {17'h0, blk_cnt_r, xoff_rcv_r, tx_st_r != TX_IDLE, tx_full_r, rx_full_r};
      A_ISTS: rdata = {28'h000_0000, sts_r};
      A_IMSK: rdata = {28'h000_0000, mask_r};
      default: hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup phase so the access phase completes at once.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      prdata_r <= rdata;
    end
  end
  assign prdata_o = prdata_r;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cfg_r <= cfg_s'(CFG_DEF);
      div_r <= DIV_DEF;
      thr_r <= THR_DEF;
      idle_set_r <= IDLE_DEF;
      win_set_r <= WIN_DEF;
      mask_r <= 4'h0;
    end else if (apb_wr) begin
      case (paddr_i)
        A_CTRL: cfg_r <= cfg_s'(pwdata_i[9:0]);
        A_BAUD: div_r <= pwdata_i[15:0];
        A_THR: thr_r <= pwdata_i[10:0];
        A_IDLE: idle_set_r <= pwdata_i[15:0];
        A_WIN: win_set_r <= pwdata_i[15:0];
        A_IMSK: mask_r <= pwdata_i[3:0];
        default: mask_r <= mask_r;
      endcase
    end
  end

  // Sixteen ticks per bit; a divider of zero behaves as one.
  assign os_tick = os_cnt_r + 16'h0001 >= div_r;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || os_tick) begin
      os_cnt_r <= 16'h0000;
    end else begin
      os_cnt_r <= os_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rx_s0_r <= 1'b1;
      rx_s1_r <= 1'b1;
      cts_s0_r <= 1'b1;
      cts_s1_r <= 1'b1;
    end else begin
      rx_s0_r <= rxd_i;
      rx_s1_r <= rx_s0_r;
      cts_s0_r <= cts_n_i;
      cts_s1_r <= cts_s0_r;
    end
  end

  // Receiver: the start edge restarts the tick count, so samples land within one tick of mid-bit.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rx_st_r <= RX_IDLE;
      rx_tk_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_par_r <= 1'b0;
      perr_r <= 1'b0;
    end else begin
      case (rx_st_r)
        RX_IDLE: begin
          rx_tk_r <= 4'h0;
          rx_bit_r <= 3'h0;
          rx_par_r <= 1'b0;
          perr_r <= 1'b0;
          if (!rx_s1_r) begin
            rx_st_r <= RX_START;
          end
        end
        RX_START: begin
          if (os_tick) begin
            rx_tk_r <= rx_tk_r + 4'h1;
            if (rx_tk_r == TK_MID) begin
              rx_tk_r <= 4'h0;
              rx_st_r <= rx_s1_r ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (os_tick) begin
            rx_tk_r <= rx_tk_r + 4'h1;
            if (rx_tk_r == TK_END) begin
              rx_sh_r <= {rx_s1_r, rx_sh_r[7:1]};
              rx_par_r <= rx_par_r ^ rx_s1_r;
              rx_bit_r <= rx_bit_r + 3'h1;
              if (rx_bit_r == last_bit) begin
                rx_st_r <= cfg_r.par == PAR_NONE ? RX_STOP : RX_PAR;
              end
            end
          end
        end
        RX_PAR: begin
          if (os_tick) begin
            rx_tk_r <= rx_tk_r + 4'h1;
            if (rx_tk_r == TK_END) begin
              perr_r <= rx_par_r ^ rx_s1_r ^ (cfg_r.par == PAR_ODD);
              rx_st_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (os_tick) begin
            rx_tk_r <= rx_tk_r + 4'h1;
            if (rx_tk_r == TK_END) begin
              rx_st_r <= RX_IDLE;
            end
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  assign rx_done = rx_st_r == RX_STOP && os_tick && rx_tk_r == TK_END;
  assign rx_byte = cfg_r.data7 ? {1'b0, rx_sh_r[7:1]} : rx_sh_r;
  assign ctl_rx = sw_fc && (rx_byte == CH_XON || rx_byte == CH_XOFF);
  assign store = rx_done && !ctl_rx;

  // A new byte wins over a pop or a clear in the same cycle.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rx_full_r <= 1'b0;
      rx_data_r <= 8'h00;
    end else begin
      if (store) begin
        rx_full_r <= 1'b1;
        rx_data_r <= rx_byte;
      end else if (clr_rx || (apb_rd && paddr_i == A_RXD)) begin
        rx_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      xoff_rcv_r <= 1'b0;
      xoff_sent_r <= 1'b0;
      rts_n_r <= 1'b0;
    end else begin
      rts_n_r <= hw_fc && rx_full_r;
      if (!sw_fc) begin
        xoff_rcv_r <= 1'b0;
        xoff_sent_r <= 1'b0;
      end else begin
        if (rx_done && ctl_rx) begin
          xoff_rcv_r <= rx_byte == CH_XOFF;
        end
        if (tx_ld && pend_x) begin
          xoff_sent_r <= rx_full_r;
        end
      end
    end
  end
  assign rts_n_o = rts_n_r;

  // Flow characters jump ahead of held data and ignore a received XOFF.
  assign pend_x = sw_fc && (rx_full_r != xoff_sent_r);
  assign tx_go = tx_full_r && !(hw_fc && cts_s1_r) && !xoff_rcv_r;
  assign tx_ld = tx_st_r == TX_IDLE && (pend_x || tx_go);

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      tx_full_r <= 1'b0;
      tx_hold_r <= 8'h00;
    end else if (clr_tx) begin
      tx_full_r <= 1'b0;
    end else if (apb_wr && paddr_i == A_TXD) begin
      tx_full_r <= 1'b1;
      tx_hold_r <= pwdata_i[7:0];
    end else if (tx_ld && !pend_x) begin
      tx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      tx_st_r <= TX_IDLE;
      tx_tk_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_par_r <= 1'b0;
      txd_r <= 1'b1;
    end else begin
      case (tx_st_r)
        TX_IDLE: begin
          tx_tk_r <= 4'h0;
          tx_bit_r <= 3'h0;
          txd_r <= 1'b1;
          if (tx_ld) begin
            tx_sh_r <= pend_x ? (rx_full_r ? CH_XOFF : CH_XON) : tx_hold_r;
            tx_par_r <= (cfg_r.par == PAR_ODD) ^
                        ^((pend_x ? (rx_full_r ? CH_XOFF : CH_XON) : tx_hold_r) &
                          {!cfg_r.data7, 7'h7F});
            txd_r <= 1'b0;
            tx_st_r <= TX_START;
          end
        end
        TX_START: begin
          if (os_tick) begin
            tx_tk_r <= tx_tk_r + 4'h1;
            if (tx_tk_r == TK_END) begin
              txd_r <= tx_sh_r[0];
              tx_st_r <= TX_DATA;
            end
          end
        end
        TX_DATA: begin
          if (os_tick) begin
            tx_tk_r <= tx_tk_r + 4'h1;
            if (tx_tk_r == TK_END) begin
              tx_sh_r <= {1'b0, tx_sh_r[7:1]};
              tx_bit_r <= tx_bit_r + 3'h1;
              txd_r <= tx_sh_r[1];
              if (tx_bit_r == last_bit) begin
                tx_bit_r <= 3'h0;
                txd_r <= cfg_r.par == PAR_NONE ? 1'b1 : tx_par_r;
                tx_st_r <= cfg_r.par == PAR_NONE ? TX_STOP : TX_PAR;
              end
            end
          end
        end
        TX_PAR: begin
          if (os_tick) begin
            tx_tk_r <= tx_tk_r + 4'h1;
            if (tx_tk_r == TK_END) begin
              txd_r <= 1'b1;
              tx_st_r <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (os_tick) begin
            tx_tk_r <= tx_tk_r + 4'h1;
            if (tx_tk_r == TK_END) begin
              tx_bit_r <= 3'h1;
              if (!cfg_r.stop2 || tx_bit_r != 3'h0) begin
                tx_st_r <= TX_IDLE;
              end
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end
  assign txd_o = txd_r;

  assign ms_tick = ms_pre_r == 32'(MS_CYCLES - 1);
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || ms_tick) begin
      ms_pre_r <= 32'h0000_0000;
    end else begin
      ms_pre_r <= ms_pre_r + 32'h0000_0001;
    end
  end

  // Blocks are released only in data-bridge mode; console traffic just accumulates.
  assign fire = cfg_r.bridge && blk_cnt_r != 11'h000 &&
                ((cfg_r.cnt_en && blk_cnt_r >= thr_r) ||
                 (cfg_r.idle_en && idle_ms_r >= idle_set_r) ||
                 (cfg_r.win_en && win_ms_r >= win_set_r));

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      blk_cnt_r <= 11'h000;
      idle_ms_r <= 16'h0000;
      win_ms_r <= 16'h0000;
      blk_rel_r <= 1'b0;
    end else begin
      blk_rel_r <= fire;
      if (clr_rx || fire) begin
        blk_cnt_r <= {10'h000, store};
        idle_ms_r <= 16'h0000;
        win_ms_r <= 16'h0000;
      end else begin
        if (store && blk_cnt_r != 11'h7FF) begin
          blk_cnt_r <= blk_cnt_r + 11'h001;
        end
        if (store) begin
          idle_ms_r <= 16'h0000;
        end else if (ms_tick && idle_ms_r != 16'hFFFF) begin
          idle_ms_r <= idle_ms_r + 16'h0001;
        end
        if (ms_tick && blk_cnt_r != 11'h000 && win_ms_r != 16'hFFFF) begin
          win_ms_r <= win_ms_r + 16'h0001;
        end
      end
    end
  end
  assign blk_rel_o = blk_rel_r;

  assign ev = {store && rx_full_r && !clr_rx, blk_rel_r, rx_done && perr_r, store};
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sts_r <= 4'h0;
    end else if (apb_wr && paddr_i == A_ISTS) begin
      sts_r <= (sts_r & ~pwdata_i[3:0]) | ev;
    end else begin
      sts_r <= sts_r | ev;
    end
  end
  assign irq_o = |(sts_r & mask_r);

  property p_rts;
    @(posedge clk_sys_i) disable iff (!nrst_i) hw_fc && rx_full_r |=> rts_n_o;
  endproperty
  a_rts: assert property (p_rts) else $error("RTS not raised when full");

  property p_mode;
    @(posedge clk_sys_i) disable iff (!nrst_i) !cfg_r.bridge |-> !pend_x ##1 !rts_n_o;
  endproperty
  a_mode: assert property (p_mode) else $error("Flow control active in console");

  property p_cnt;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      cfg_r.bridge && cfg_r.cnt_en && blk_cnt_r != 11'h000 && blk_cnt_r >= thr_r |=> blk_rel_o;
  endproperty
  a_cnt: assert property (p_cnt) else $error("Byte count did not release");

  property p_restart;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      blk_rel_o |-> blk_cnt_r <= 11'h001 && win_ms_r == 16'h0000 && idle_ms_r == 16'h0000;
  endproperty
  a_restart: assert property (p_restart) else $error("Counters not restarted");

  property p_clr_rx;
    @(posedge clk_sys_i) disable iff (!nrst_i) clr_rx && !store |=> !rx_full_r;
  endproperty
  a_clr_rx: assert property (p_clr_rx) else $error("Receive buffer not cleared");

  property p_clr_tx;
    @(posedge clk_sys_i) disable iff (!nrst_i) clr_tx |=> !tx_full_r;
  endproperty
  a_clr_tx: assert property (p_clr_tx) else $error("Transmit buffer not cleared");

  property p_stop;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      tx_st_r == TX_STOP || tx_st_r == TX_IDLE |-> txd_o;
  endproperty
  a_stop: assert property (p_stop) else $error("Stop level low");

  property p_perr;
    @(posedge clk_sys_i) disable iff (!nrst_i) rx_done && perr_r |=> sts_r[I_PERR];
  endproperty
  a_perr: assert property (p_perr) else $error("Parity error not reported");

  property p_xoff;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      sw_fc && rx_full_r && !xoff_sent_r && tx_st_r == TX_IDLE |=> tx_sh_r == CH_XOFF;
  endproperty
  a_xoff: assert property (p_xoff) else $error("XOFF not sent");

endmodule // uart_packetizer

// file: hdl/uart_pkt_pkg.sv
// Notes on behaviour
// - Software picks bit rate; default 9600 baud.
// - Seven or eight data bits; eight after reset.
// - Parity none, even or odd; none after reset.
// - Receiver flags parity mismatch as error.
// - One or two stop bits; one after reset.
// - Flow control only in data-bridge mode.
// - Hardware flow uses RTS and CTS lines.
// - Software flow sends XOFF, then XON.
// - Byte-count trigger releases block, default 128.
// - Idle-timeout trigger in ms since last character.
// - Window trigger in ms since first character.
// - Clear command empties receive buffer.
// - Clear command empties transmit buffer.
// - Console or data-bridge mode; console after reset.
package uart_pkt_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int CLK_NS = 4;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam int OS = 16;
  localparam int BAUD_DEF = 9600;
  localparam logic [15:0] DIV_DEF = 16'((CLK_HZ + OS * BAUD_DEF / 2) / (OS * BAUD_DEF));
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BAUD = 8'h04;
  localparam logic [7:0] A_THR = 8'h08;
  localparam logic [7:0] A_IDLE = 8'h0C;
  localparam logic [7:0] A_WIN = 8'h10;
  localparam logic [7:0] A_CMD = 8'h14;
  localparam logic [7:0] A_TXD = 8'h18;
  localparam logic [7:0] A_RXD = 8'h1C;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_ISTS = 8'h24;
  localparam logic [7:0] A_IMSK = 8'h28;
  localparam int CMD_CLR_RX = 0;
  localparam int CMD_CLR_TX = 1;
  localparam int I_RX = 0;
  localparam int I_PERR = 1;
  localparam int I_BLK = 2;
  localparam int I_OVR = 3;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] FLOW_HW = 2'h1;
  localparam logic [1:0] FLOW_SW = 2'h2;
  localparam logic [10:0] THR_DEF = 11'h080;
  localparam logic [15:0] IDLE_DEF = 16'h0000;
  localparam logic [15:0] WIN_DEF = 16'h0064;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [3:0] TK_MID = 4'h7;
  localparam logic [3:0] TK_END = 4'hF;
  typedef struct packed {
    logic win_en;
    logic idle_en;
    logic cnt_en;
    logic [1:0] flow;
    logic stop2;
    logic [1:0] par;
    logic data7;
    logic bridge;
  } cfg_s;
  localparam logic [9:0] CFG_DEF = 10'h180;
endpackage

// file: tb/serial_terminal.sv
`timescale 1ns/1ps
module serial_terminal #(
  parameter int BIT_CYC = 32
) (
  // Clock
  input wire logic clk_i,
  // Line
  input wire logic line_i,
  output logic line_o,
  output logic cts_n_o,
  input wire logic rts_n_i,
  // Frame format
  input wire logic data7_i,
  input wire logic [1:0] par_i,
  input wire logic stop2_i
);
  logic [7:0] rx_q[$];
  int bad_cnt = 0;
  // The line is driven high at idle, and CTS starts low so the port may send at once.
  initial begin
    line_o = 1'b1;
    cts_n_o = 1'b0;
  end
  function automatic logic par_bit(input logic [7:0] d);
    par_bit = (^(data7_i ? {1'b0, d[6:0]} : d)) ^ (par_i == 2'h2);
  endfunction
  task automatic bit_out(input logic b);
    line_o <= b;
    repeat (BIT_CYC) @(posedge clk_i);
  endtask
  // A set flip sends the wrong parity on purpose.
  task automatic send(input logic [7:0] d, input logic flip);
    // The terminal holds back while the port asks it to stop.
    for (int n = 0; n < 5000 && rts_n_i === 1'b1; n++) @(posedge clk_i);
    @(posedge clk_i);
    bit_out(1'b0);
    for (int i = 0; i < (data7_i ? 7 : 8); i++) bit_out(d[i]);
    if (par_i != 2'h0) bit_out(par_bit(d) ^ flip);
    bit_out(1'b1);
    if (stop2_i) bit_out(1'b1);
  endtask
  always begin : rx_proc
    logic [7:0] d;
    logic ok;
    @(negedge line_i);
    d = 8'h00;
    repeat (BIT_CYC / 2) @(posedge clk_i);
    ok = (line_i === 1'b0);
    for (int i = 0; i < (data7_i ? 7 : 8); i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      d[i] = line_i;
    end
    if (par_i != 2'h0) begin
      repeat (BIT_CYC) @(posedge clk_i);
      ok &= (line_i === par_bit(d));
    end
    repeat (BIT_CYC) @(posedge clk_i);
    ok &= (line_i === 1'b1);
    if (stop2_i) begin
      repeat (BIT_CYC) @(posedge clk_i);
      ok &= (line_i === 1'b1);
    end
    if (!ok) bad_cnt++;
    rx_q.push_back(d);
  end
endmodule // serial_terminal

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import uart_pkt_pkg::*;
  localparam int BIT_CYC = 32;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rxd, txd, cts_n, rts_n, irq, blk_rel;
  logic data7 = 1'b0;
  logic stop2 = 1'b0;
  logic [1:0] par = 2'h0;
  logic [3:0] fmts [4] = '{4'h0, 4'hB, 4'h4, 4'h1};
  logic [3:0] f;
  logic [31:0] rd;
  logic se;
  int error_cnt = 0;
  int cmp_count = 0;
  int blk_cnt = 0;
  int b0;
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (blk_rel === 1'b1) blk_cnt <= blk_cnt + 1;
  uart_packetizer #(.MS_CYCLES(20)) dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rxd_i(rxd), .txd_o(txd),
    .cts_n_i(cts_n), .rts_n_o(rts_n), .irq_o(irq), .blk_rel_o(blk_rel));
  serial_terminal #(.BIT_CYC(BIT_CYC)) term_u (.clk_i(clk_sys_i), .line_i(txd), .line_o(rxd),
    .cts_n_o(cts_n), .rts_n_i(rts_n), .data7_i(data7), .par_i(par), .stop2_i(stop2));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // An idle cycle follows every transfer so that no strobe is driven twice in one step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin error_cnt++; finish_test(); end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hFFFFFFFF);
    apb(1'b0, a, 32'h0);
    check(nm, rd & m, exp);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) === 32'h0 && n < 3000);
    if (n >= 3000) begin error_cnt++; finish_test(); end
  endtask
  task automatic wait_q();
    int n;
    n = 0;
    while (term_u.rx_q.size() == 0 && n < 3000) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 3000) begin error_cnt++; finish_test(); end
  endtask
  task automatic got(input string nm, input logic [7:0] exp);
    wait_q();
    check(nm, 32'(term_u.rx_q.pop_front()), 32'(exp));
  endtask
  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    rc("ctrl", A_CTRL, 32'h180);
    rc("baud", A_BAUD, 32'(DIV_DEF));
    rc("thr", A_THR, 32'h80);
    rc("idle", A_IDLE, 32'h0);
    rc("win", A_WIN, 32'h64);
    apb(1'b0, 8'h30, 32'h0);
    check("slverr", {31'h0, se}, 32'h1);
    end_test("reset");
    wr(A_BAUD, 32'h2);
    foreach (fmts[i]) begin
      f = fmts[i];
      wr(A_CTRL, {22'h0, 3'b011, 2'b00, f, 1'b0});
      data7 <= f[0];
      par <= f[2:1];
      stop2 <= f[3];
      wr(A_TXD, 32'hA5);
      got("tx byte", f[0] ? 8'h25 : 8'hA5);
      check("tx frame", 32'(term_u.bad_cnt), 32'h0);
      term_u.send(8'hC3, 1'b0);
      poll(A_STAT, 32'h1);
      rc("rx byte", A_RXD, f[0] ? 32'h43 : 32'hC3);
      rc("ists", A_ISTS, 32'h1, 32'h3);
      wr(A_ISTS, 32'hF);
      if (f[2:1] != 2'h0) begin
        term_u.send(8'h5A, 1'b1);
        poll(A_ISTS, 32'h2);
        rc("perr", A_ISTS, 32'h3, 32'h3);
        rc("perr byte", A_RXD, f[0] ? 32'h5A : 32'h5A);
        wr(A_ISTS, 32'hF);
      end
    end
    end_test("formats");
    wr(A_CTRL, 32'h184);
    data7 <= 1'b0;
    par <= 2'h1;
    stop2 <= 1'b0;
    wr(A_IMSK, 32'h2);
    term_u.send(8'h0F, 1'b0);
    poll(A_STAT, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    term_u.send(8'h0F, 1'b1);
    poll(A_ISTS, 32'h2);
    check("ists ovr", rd & 32'hF, 32'hB);
    check("irq set", {31'h0, irq}, 32'h1);
    wr(A_ISTS, 32'hF);
    check("irq clear", {31'h0, irq}, 32'h0);
    apb(1'b0, A_RXD, 32'h0);
    wr(A_IMSK, 32'h0);
    par <= 2'h0;
    end_test("interrupt");
    wr(A_CTRL, 32'h1A1);
    term_u.cts_n_o <= 1'b1;
    wr(A_TXD, 32'h5A);
    repeat (BIT_CYC * 12) @(posedge clk_sys_i);
    check("cts hold", 32'(term_u.rx_q.size()), 32'h0);
    term_u.cts_n_o <= 1'b0;
    got("cts go", 8'h5A);
    term_u.send(8'h33, 1'b0);
    poll(A_STAT, 32'h1);
    check("rts full", {31'h0, rts_n}, 32'h1);
    rc("rts byte", A_RXD, 32'h33);
    repeat (4) @(posedge clk_sys_i);
    check("rts free", {31'h0, rts_n}, 32'h0);
    end_test("hw flow");
    wr(A_CTRL, 32'h1C1);
    term_u.send(CH_XOFF, 1'b0);
    poll(A_STAT, 32'h8);
    wr(A_TXD, 32'h66);
    repeat (BIT_CYC * 12) @(posedge clk_sys_i);
    check("xoff hold", 32'(term_u.rx_q.size()), 32'h0);
    term_u.send(CH_XON, 1'b0);
    got("xon go", 8'h66);
    term_u.send(8'h41, 1'b0);
    got("xoff sent", CH_XOFF);
    rc("sw byte", A_RXD, 32'h41);
    got("xon sent", CH_XON);
    end_test("sw flow");
    wr(A_THR, 32'h2);
    wr(A_CTRL, 32'h81);
    b0 = blk_cnt;
    term_u.send(8'h01, 1'b0);
    poll(A_STAT, 32'h1);
    rc("cnt one", A_STAT, 32'h10, 32'h7FF0);
    check("no rel", 32'(blk_cnt - b0), 32'h0);
    wr(A_ISTS, 32'h4);
    apb(1'b0, A_RXD, 32'h0);
    term_u.send(8'h02, 1'b0);
    poll(A_STAT, 32'h1);
    rc("cnt rel", A_STAT, 32'h0, 32'h7FF0);
    check("cnt blk", 32'(blk_cnt - b0), 32'h1);
    rc("blk sts", A_ISTS, 32'h4, 32'h4);
    apb(1'b0, A_RXD, 32'h0);
    wr(A_IDLE, 32'h2);
    wr(A_CTRL, 32'h101);
    b0 = blk_cnt;
    term_u.send(8'h03, 1'b0);
    poll(A_STAT, 32'h1);
    repeat (4) @(posedge clk_sys_i);
    check("idle early", 32'(blk_cnt - b0), 32'h0);
    repeat (66) @(posedge clk_sys_i);
    check("idle rel", 32'(blk_cnt - b0), 32'h1);
    apb(1'b0, A_RXD, 32'h0);
    wr(A_WIN, 32'h14);
    wr(A_CTRL, 32'h201);
    b0 = blk_cnt;
    for (int k = 0; k < 2; k++) begin
      term_u.send(8'h04, 1'b0);
      poll(A_STAT, 32'h1);
      apb(1'b0, A_RXD, 32'h0);
    end
    rc("win cnt", A_STAT, 32'h20, 32'h7FF0);
    check("win early", 32'(blk_cnt - b0), 32'h0);
    repeat (100) @(posedge clk_sys_i);
    check("win rel", 32'(blk_cnt - b0), 32'h1);
    rc("win clr", A_STAT, 32'h0, 32'h7FF0);
    end_test("triggers");
    wr(A_CTRL, 32'h81);
    term_u.send(8'h05, 1'b0);
    poll(A_STAT, 32'h1);
    wr(A_CMD, 32'h1);
    rc("clr rx", A_STAT, 32'h0, 32'h7FF1);
    wr(A_CTRL, 32'h180);
    wr(A_TXD, 32'h77);
    wr(A_TXD, 32'h88);
    wr(A_CMD, 32'h2);
    repeat (BIT_CYC * 25) @(posedge clk_sys_i);
    check("clr tx n", 32'(term_u.rx_q.size()), 32'h1);
    got("clr tx b", 8'h77);
    end_test("clear");
    finish_test();
  end
endmodule // testbench
